// >>> rcd_core.sv
// Function
// - Medium jump adds a 28-bit offset from two words to the program counter.
// - Read-pc writes current pc plus unsigned low-nibble immediate to dest.
// - Small add puts src plus signed low nibble into dest; zero copies.
// - Halfword immediate loads next word into dest low half, upper cleared.
// - Fullword immediate loads two extra words, upper first, into dest.
// - Set vector copies the source register into the interrupt vector.
// - Interrupt return reloads pc from saved interrupt return address.
// - Trace return reloads saved pc; that instruction runs before next trace.
// - Read extended copies the upper multiply result into dest.
// - Read trace return copies saved trace return address into dest.
// - Write control word copies register named in bits 7..4 to control.
// - Swap group exchanges low bytes or the two halves into dest.
// - Shift right by one, zero or sign fill, low bit dropped.
// - Invert writes the bitwise complement of source into dest.
// - Store writes source to address in Y, half or full big-endian.
// - Load reads from address in X into dest, half, full or sign-extended.
// - Level interrupt taken when control bit 0 set; saves pc, jumps vector.
// - With control bit 31, each instruction outside the trace handler saves next pc, jumps to 2.
// - Trace event wins over a coinciding interrupt.
// - Stall input high freezes all state and outputs.
// - Memory access by read and write strobes, 16-bit data, 32-bit address.
// - All interface inputs are sampled on the rising clock edge.
// - Instruction fields: opcode 15..12, Y 11..8, Z 7..4, X 3..0.
// - Reset clears control word and starts execution at address zero.
`timescale 1ns/100ps
`include "rcd_params.svh"

module rcd_core (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic stall_request,
  input wire logic irq_request,
  input wire logic [15:0] read_data_bus,
  input wire logic [31:0] extended_result_reg,
  output logic [15:0] write_data_bus,
  output logic [31:0] address_bus,
  output logic read_strobe,
  output logic write_strobe
);

  rcd_pkg::rcd_state_t state;
  rcd_pkg::rcd_state_t next_state;
  logic [15:0] instr;
  logic [31:0] pc;
  logic [31:0] control_word_reg;
  logic [31:0] irq_vector_reg;
  logic [31:0] irq_return_reg;
  logic [31:0] trace_return_reg;
  logic [15:0] hold_word;
  logic in_trace;
  logic in_irq;
  logic [3:0] opcode;
  logic [3:0] sub;
  logic [3:0] fld_z;
  logic [3:0] fld_x;
  logic [31:0] src_x;
  logic [31:0] src_y;
  logic [31:0] src_z;
  logic [31:0] unary_result;
  logic step;
  logic finish;
  logic [31:0] finish_pc;
  logic take_trace;
  logic take_irq;
  logic [31:0] next_pc;
  logic rf_we;
  logic [31:0] rf_wdata;
  logic [31:0] next_addr;
  logic [15:0] next_wdata;
  logic next_rd;
  logic next_wr;

  // Field split of the held instruction
  assign opcode = instr[15:12];
  assign sub = instr[11:8];
  assign fld_z = instr[7:4];
  assign fld_x = instr[3:0];

  // Nothing advances while the bus unit holds the stall line
  assign step = !stall_request;

  rcd_regfile u_regs (
    .mclk(mclk),
    .wr_en(rf_we),
    .wr_addr(fld_z),
    .wr_data(rf_wdata),
    .rd_addr_a(fld_x),
    .rd_addr_b(sub),
    .rd_addr_c(fld_z),
    .rd_data_a(src_x),
    .rd_data_b(src_y),
    .rd_data_c(src_z)
  );

  rcd_unary u_unary (
    .opcode(opcode),
    .sub(sub),
    .imm(fld_x),
    .src_x(src_x),
    .src_hi(src_y),
    .result(unary_result)
  );

  // Instruction completion and the program counter it leaves behind
  always_comb begin
    finish = 1'b0;
    finish_pc = pc + 32'h00000001;
    case (state)
      rcd_pkg::RCD_EXEC: begin
        finish = 1'b1;
        case (opcode)
          `RCD_OP_MED_JUMP: finish = 1'b0;
          `RCD_OP_STORE: finish = 1'b0;
          `RCD_OP_LOAD: finish = 1'b0;
          `RCD_OP_CTRL: begin
            if (sub == `RCD_SUB_IMM_HALF || sub == `RCD_SUB_IMM_FULL) begin
              finish = 1'b0;
            end else if (sub == `RCD_SUB_RET_IRQ) begin
              finish_pc = irq_return_reg;
            end else if (sub == `RCD_SUB_RET_TRACE) begin
              finish_pc = trace_return_reg;
            end
          end
          default: finish = 1'b1;
        endcase
      end
      rcd_pkg::RCD_EXT1: begin
        if (opcode == `RCD_OP_MED_JUMP) begin
          finish = 1'b1;
          finish_pc = pc + {{4{instr[11]}}, instr[11:0], read_data_bus};
        end else if (sub == `RCD_SUB_IMM_HALF) begin
          finish = 1'b1;
          finish_pc = pc + 32'h00000002;
        end
      end
      rcd_pkg::RCD_EXT2: begin
        finish = 1'b1;
        finish_pc = pc + 32'h00000003;
      end
      rcd_pkg::RCD_MEM_HI: begin
        finish = (opcode == `RCD_OP_STORE) ? (fld_z != `RCD_MOVE_FULL)
                                           : (sub != `RCD_MOVE_FULL);
      end
      rcd_pkg::RCD_MEM_LO: finish = 1'b1;
      default: finish = 1'b0;
    endcase
  end

  // Event selection at an instruction boundary; trace first
  assign take_trace = finish && control_word_reg[`RCD_CTLWORD_TRACE_BIT] && !in_trace;
  assign take_irq = finish && !take_trace && irq_request
                    && control_word_reg[`RCD_CTLWORD_IRQ_BIT] && !in_irq;

  always_comb begin
    if (take_trace) begin
      next_pc = `RCD_TRACE_HANDLER;
    end else if (take_irq) begin
      next_pc = irq_vector_reg;
    end else begin
      next_pc = finish_pc;
    end
  end

  // Register file write data and enable
  always_comb begin
    rf_we = 1'b0;
    rf_wdata = unary_result;
    case (state)
      rcd_pkg::RCD_EXEC: begin
        case (opcode)
          `RCD_OP_READ_PC: begin
            rf_we = 1'b1;
            rf_wdata = pc + {28'h0000000, fld_x};
          end
          `RCD_OP_ADD_SMALL, `RCD_OP_SWAP, `RCD_OP_SHIFT: begin
            rf_we = 1'b1;
          end
          `RCD_OP_CTRL: begin
            if (sub == `RCD_SUB_READ_EXT) begin
              rf_we = 1'b1;
              rf_wdata = extended_result_reg;
            end else if (sub == `RCD_SUB_READ_TRACE) begin
              rf_we = 1'b1;
              rf_wdata = trace_return_reg;
            end
          end
          default: rf_we = 1'b0;
        endcase
      end
      rcd_pkg::RCD_EXT1: begin
        rf_we = (opcode == `RCD_OP_CTRL) && (sub == `RCD_SUB_IMM_HALF);
        rf_wdata = {16'h0000, read_data_bus};
      end
      rcd_pkg::RCD_EXT2: begin
        rf_we = 1'b1;
        rf_wdata = {hold_word, read_data_bus};
      end
      rcd_pkg::RCD_MEM_HI: begin
        rf_we = (opcode == `RCD_OP_LOAD) && (sub != `RCD_MOVE_FULL);
        if (sub == `RCD_MOVE_HALF_SX) begin
          rf_wdata = {{16{read_data_bus[15]}}, read_data_bus};
        end else begin
          rf_wdata = {16'h0000, read_data_bus};
        end
      end
      rcd_pkg::RCD_MEM_LO: begin
        rf_we = (opcode == `RCD_OP_LOAD);
        rf_wdata = {hold_word, read_data_bus};
      end
      default: rf_we = 1'b0;
    endcase
    rf_we = rf_we && step;
  end

  // Sequencer and the bus request it will present next
  always_comb begin
    next_state = state;
    next_addr = address_bus;
    next_wdata = write_data_bus;
    next_rd = 1'b0;
    next_wr = 1'b0;
    if (finish) begin
      next_state = rcd_pkg::RCD_FETCH;
      next_addr = next_pc;
      next_rd = 1'b1;
    end else begin
      case (state)
        rcd_pkg::RCD_FETCH: begin
          next_state = rcd_pkg::RCD_EXEC;
        end
        rcd_pkg::RCD_EXEC: begin
          if (opcode == `RCD_OP_STORE) begin
            next_state = rcd_pkg::RCD_MEM_HI;
            next_addr = src_y;
            next_wdata = (fld_z == `RCD_MOVE_FULL) ? src_x[31:16] : src_x[15:0];
            next_wr = 1'b1;
          end else if (opcode == `RCD_OP_LOAD) begin
            next_state = rcd_pkg::RCD_MEM_HI;
            next_addr = src_x;
            next_rd = 1'b1;
          end else begin
            next_state = rcd_pkg::RCD_EXT1;
            next_addr = pc + 32'h00000001;
            next_rd = 1'b1;
          end
        end
        rcd_pkg::RCD_EXT1: begin
          next_state = rcd_pkg::RCD_EXT2;
          next_addr = pc + 32'h00000002;
          next_rd = 1'b1;
        end
        rcd_pkg::RCD_MEM_HI: begin
          next_state = rcd_pkg::RCD_MEM_LO;
          next_addr = address_bus + 32'h00000001;
          next_wdata = src_x[15:0];
          next_rd = (opcode == `RCD_OP_LOAD);
          next_wr = (opcode == `RCD_OP_STORE);
        end
        default: next_state = rcd_pkg::RCD_FETCH;
      endcase
    end
  end

  // State and bus outputs, frozen while stalled
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= rcd_pkg::RCD_FETCH;
      address_bus <= `RCD_PC_RESET;
      write_data_bus <= 16'h0000;
      read_strobe <= 1'b1;
      write_strobe <= 1'b0;
    end else if (step) begin
      state <= next_state;
      address_bus <= next_addr;
      write_data_bus <= next_wdata;
      read_strobe <= next_rd;
      write_strobe <= next_wr;
    end
  end

  // Program counter only moves at instruction boundaries
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pc <= `RCD_PC_RESET;
    end else if (step && finish) begin
      pc <= next_pc;
    end
  end

  // Instruction and first extra word capture
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      instr <= 16'h0000;
      hold_word <= 16'h0000;
    end else if (step) begin
      if (state == rcd_pkg::RCD_FETCH) begin
        instr <= read_data_bus;
      end
      if (state == rcd_pkg::RCD_EXT1 || state == rcd_pkg::RCD_MEM_HI) begin
        hold_word <= read_data_bus;
      end
    end
  end

  // Control word and interrupt vector writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      control_word_reg <= `RCD_CTLWORD_RESET;
      irq_vector_reg <= 32'h00000000;
    end else if (step && state == rcd_pkg::RCD_EXEC && opcode == `RCD_OP_CTRL) begin
      if (sub == `RCD_SUB_SET_CTLWORD) begin
        control_word_reg <= src_z;
      end
      if (sub == `RCD_SUB_SET_VEC) begin
        irq_vector_reg <= src_x;
      end
    end
  end

  // Return addresses; a handler flag stops re-entry while it runs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_return_reg <= 32'h00000000;
      trace_return_reg <= 32'h00000000;
      in_trace <= 1'b0;
      in_irq <= 1'b0;
    end else if (step && finish) begin
      if (take_trace) begin
        trace_return_reg <= finish_pc;
        in_trace <= 1'b1;
      end else if (state == rcd_pkg::RCD_EXEC && opcode == `RCD_OP_CTRL
                   && sub == `RCD_SUB_RET_TRACE) begin
        in_trace <= 1'b0;
      end
      if (take_irq) begin
        irq_return_reg <= finish_pc;
        in_irq <= 1'b1;
      end else if (state == rcd_pkg::RCD_EXEC && opcode == `RCD_OP_CTRL
                   && sub == `RCD_SUB_RET_IRQ) begin
        in_irq <= 1'b0;
      end
    end
  end

endmodule // rcd_core

// >>> rcd_core_bench.sv
`timescale 1ns/100ps

module rcd_core_bench;
  logic mclk, sys_rst, irq_request, slow, read_strobe, write_strobe, stall_request;
  logic [15:0] write_data_bus, read_data_bus;
  logic [31:0] address_bus, extended_result_reg;
  int errors = 0;
  int n_compared = 0;

  rcd_core u_rcd_core (.mclk(mclk), .sys_rst(sys_rst), .stall_request(stall_request),
    .irq_request(irq_request), .read_data_bus(read_data_bus),
    .extended_result_reg(extended_result_reg), .write_data_bus(write_data_bus),
    .address_bus(address_bus), .read_strobe(read_strobe), .write_strobe(write_strobe));
  rcd_mem_model u_rcd_mem_model (.mclk(mclk), .slow(slow), .address_bus(address_bus),
    .read_strobe(read_strobe), .write_strobe(write_strobe), .write_data_bus(write_data_bus),
    .read_data_bus(read_data_bus), .stall_request(stall_request));

  // 25 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  function automatic logic [31:0] rd32(input int a);
    return {u_rcd_mem_model.mem[a], u_rcd_mem_model.mem[a + 1]};
  endfunction

  // Reset first, then reload memory, so the old program never fetches new words
  task automatic boot(input logic s, input logic [15:0] p[$]);
    @(negedge mclk);
    slow = s;
    sys_rst = 1'b1;
    for (int i = 0; i < 1024; i++) u_rcd_mem_model.mem[i] = 16'h0000;
    foreach (p[i]) u_rcd_mem_model.mem[i] = p[i];
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
  endtask

  // Bounded wait for a completed read (w=0) or write (w=1) at an address
  task automatic run_to(input logic [31:0] a, input bit w);
    int n;
    for (n = 0; n < 400; n++) begin
      @(negedge mclk);
      if ((w ? write_strobe : read_strobe) === 1'b1 && !stall_request && address_bus === a) break;
    end
    if (n == 400) begin
      errors++;
      $display("[FAIL] %0t no access at %h", $time, a);
      end_of_test;
    end
  endtask

  // Register ops on one value, then read-pc and read-extended, each result stored as a big-endian pair
  task automatic t_unary;
    logic [31:0] expv [9] = '{32'h81236745, 32'h45678123, 32'h4091A2B3, 32'hC091A2B3,
      32'h7EDCBA98, 32'h8123456B, 32'h81234566, 32'h0000001C, 32'h13579BDF};
    boot(1'b0, '{16'hB110, 16'h8123, 16'h4567, 16'hB020, 16'h0100,
      16'hC031, 16'hE213, 16'hA222, 16'hC131, 16'hE213, 16'hA222,
      16'hD031, 16'hE213, 16'hA222, 16'hD131, 16'hE213, 16'hA222,
      16'hD231, 16'hE213, 16'hA222, 16'hA134, 16'hE213, 16'hA222,
      16'hA13F, 16'hE213, 16'hA222, 16'h9032, 16'hE213, 16'hA222,
      16'hB630, 16'hE213, 16'hA222, 16'h8000, 16'h0000});
    run_to(32'h20, 1'b0);
    for (int k = 0; k < 5; k++) begin
      check(rd32(256 + 2 * k), expv[k]);
    end
    for (int k = 5; k < 9; k++) begin
      check(rd32(256 + 2 * k), expv[k]);
    end
  endtask

  // Memory moves with a wait cycle on every access
  task automatic t_moves;
    boot(1'b1, '{16'hB150, 16'hFFFF, 16'hFFFF, 16'hB050, 16'h0300, 16'hB020, 16'h0200,
      16'hF065, 16'hF275, 16'hF185, 16'hE215, 16'hA222, 16'hE216, 16'hA222, 16'hE217,
      16'hA222, 16'hE218, 16'hA222, 16'hE206, 16'h8000, 16'h0000});
    u_rcd_mem_model.mem[768] = 16'h8ABC;
    u_rcd_mem_model.mem[769] = 16'h1234;
    u_rcd_mem_model.mem[521] = 16'h7777;
    run_to(32'h13, 1'b0);
    check(rd32(512), 32'h00000300);
    check(rd32(514), 32'h00008ABC);
    check(rd32(516), 32'hFFFF8ABC);
    check(rd32(518), 32'h8ABC1234);
    check({u_rcd_mem_model.mem[520], u_rcd_mem_model.mem[521]}, 32'h8ABC7777);
  endtask

  // Request held high from reset; masked until the control word enables it
  task automatic t_irq;
    irq_request = 1'b1;
    boot(1'b0, '{16'hB020, 16'h0200, 16'hB090, 16'h0040, 16'hB209, 16'hB0A0, 16'h0001,
      16'hB4A0, 16'h8000, 16'h0004, 16'h8000, 16'h0000, 16'h8000, 16'h0000});
    u_rcd_mem_model.mem[64] = 16'hB0B0;
    u_rcd_mem_model.mem[65] = 16'h00AA;
    u_rcd_mem_model.mem[66] = 16'hE20B;
    u_rcd_mem_model.mem[67] = 16'hB300;
    run_to(32'h200, 1'b1);
    irq_request = 1'b0;
    run_to(32'hC, 1'b0);
    check({16'h0000, u_rcd_mem_model.mem[512]}, 32'h000000AA);
  endtask

  // Single step: handler at 2 logs each return address
  task automatic t_trace;
    boot(1'b0, '{16'h8000, 16'h0010, 16'hB7C0, 16'hE21C, 16'hA222, 16'hB500,
      16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'hB020, 16'h0200, 16'hB1A0, 16'h8000, 16'h0000, 16'hB4A0, 16'hA111,
      16'hA111, 16'hB0A0, 16'h0000, 16'hB4A0, 16'h8000, 16'h0000});
    run_to(32'h1B, 1'b0);
    // Let the final loop run long enough for a stray trace entry to land
    repeat (20) @(negedge mclk);
    check(rd32(512), 32'h00000017);
    check(rd32(514), 32'h00000018);
    check(rd32(516), 32'h0000001A);
    check(rd32(518), 32'h0000001B);
    check(rd32(520), 32'h00000000);
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    irq_request = 1'b0;
    slow = 1'b0;
    extended_result_reg = 32'h13579BDF;
    t_unary;
    t_moves;
    t_irq;
    t_trace;
    end_of_test;
  end
endmodule // rcd_core_bench

bind rcd_core rcd_core_chk u_rcd_core_chk (.mclk(mclk), .sys_rst(sys_rst),
  .stall_request(stall_request), .write_data_bus(write_data_bus),
  .address_bus(address_bus), .read_strobe(read_strobe), .write_strobe(write_strobe));

// >>> rcd_core_sva.sv
`timescale 1ns/100ps

module rcd_core_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic stall_request,
  input wire logic [15:0] write_data_bus,
  input wire logic [31:0] address_bus,
  input wire logic read_strobe,
  input wire logic write_strobe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Reset parks the bus on a fetch from zero
  a_reset_fetch_zero: assert property (disable iff (1'b0)
    sys_rst |=> address_bus == 32'h00000000 && read_strobe && !write_strobe)
    else $error("bus not parked on fetch from zero in reset");
  a_first_fetch: assert property ($fell(sys_rst) |->
    address_bus == 32'h00000000 && read_strobe)
    else $error("first access after reset not a fetch from zero");
  // A stall freezes every output
  a_stall_freeze: assert property (stall_request |=> $stable(address_bus) &&
    $stable(read_strobe) && $stable(write_strobe) && $stable(write_data_bus))
    else $error("outputs moved during stall");
  a_strobe_excl: assert property (!(read_strobe && write_strobe))
    else $error("read and write requested together");
  // Execute is one idle cycle, never two
  a_exec_single: assert property (!read_strobe && !write_strobe && !stall_request
    |=> read_strobe || write_strobe)
    else $error("two idle cycles in a row");
  // Second half of a store goes to the next word
  a_store_pair: assert property (write_strobe && !stall_request ##1 write_strobe
    |-> address_bus == $past(address_bus) + 32'h1)
    else $error("second store word not at next address");
  a_store_after_exec: assert property ($rose(write_strobe) |-> !$past(read_strobe))
    else $error("store not preceded by execute cycle");
  a_fetch_after_store: assert property ($fell(write_strobe) |-> read_strobe)
    else $error("store not followed by fetch");
endmodule // rcd_core_chk

// >>> rcd_mem_model.sv
`timescale 1ns/100ps

module rcd_mem_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic [31:0] address_bus,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [15:0] write_data_bus,
  output logic [15:0] read_data_bus,
  output logic stall_request
);
  logic [15:0] mem [0:1023];

  // Idle bus shows the inverted word so stale data cannot pass
  assign read_data_bus = read_strobe ? mem[address_bus[9:0]] : ~mem[address_bus[9:0]];

  // Slow mode adds one wait cycle to every access
  initial stall_request = 1'b0;
  always @(negedge mclk) begin
    stall_request <= slow && (read_strobe || write_strobe) && !stall_request;
  end

  // Writes land only at an unstalled edge
  always @(posedge mclk) begin
    if (write_strobe && !stall_request) mem[address_bus[9:0]] <= write_data_bus;
  end
endmodule // rcd_mem_model

// >>> rcd_params.svh
`ifndef RCD_PARAMS_SVH
`define RCD_PARAMS_SVH

// Top nibble opcodes handled by this core slice
`define RCD_OP_MED_JUMP 4'h8
`define RCD_OP_READ_PC 4'h9
`define RCD_OP_ADD_SMALL 4'hA
`define RCD_OP_CTRL 4'hB
`define RCD_OP_SWAP 4'hC
`define RCD_OP_SHIFT 4'hD
`define RCD_OP_STORE 4'hE
`define RCD_OP_LOAD 4'hF

// Sub-codes in bits 11..8 of the control group
`define RCD_SUB_IMM_HALF 4'h0
`define RCD_SUB_IMM_FULL 4'h1
`define RCD_SUB_SET_VEC 4'h2
`define RCD_SUB_RET_IRQ 4'h3
`define RCD_SUB_SET_CTLWORD 4'h4
`define RCD_SUB_RET_TRACE 4'h5
`define RCD_SUB_READ_EXT 4'h6
`define RCD_SUB_READ_TRACE 4'h7

// Sub-codes of the swap and shift groups
`define RCD_SUB_SWAP_BYTES 4'h0
`define RCD_SUB_SWAP_HALVES 4'h1
`define RCD_SUB_SHR_LOGIC 4'h0
`define RCD_SUB_SHR_ARITH 4'h1
`define RCD_SUB_INVERT 4'h2

// Size codes of the memory moves
`define RCD_MOVE_HALF 4'h0
`define RCD_MOVE_FULL 4'h1
`define RCD_MOVE_HALF_SX 4'h2

// Control word layout and reset values
`define RCD_CTLWORD_IRQ_BIT 0
`define RCD_CTLWORD_TRACE_BIT 31
`define RCD_CTLWORD_RESET 32'h00000000
`define RCD_PC_RESET 32'h00000000
`define RCD_TRACE_HANDLER 32'h00000002

`endif

// >>> rcd_pkg.sv
package rcd_pkg;

  // Sequencer states, Gray coded along fetch, execute, extra words
  typedef enum logic [2:0] {
    RCD_FETCH = 3'h0,
    RCD_EXEC = 3'h1,
    RCD_EXT1 = 3'h3,
    RCD_EXT2 = 3'h2,
    RCD_MEM_HI = 3'h6,
    RCD_MEM_LO = 3'h7
  } rcd_state_t;

endpackage

// >>> rcd_regfile.sv
`timescale 1ns/100ps

module rcd_regfile (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] rd_addr_a,
  input wire logic [3:0] rd_addr_b,
  input wire logic [3:0] rd_addr_c,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b,
  output logic [31:0] rd_data_c
);

  logic [31:0] regs [16];

  // General registers are not cleared; software must set them up
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end
  end

  // Three asynchronous read ports
  assign rd_data_a = regs[rd_addr_a];
  assign rd_data_b = regs[rd_addr_b];
  assign rd_data_c = regs[rd_addr_c];

endmodule // rcd_regfile

// >>> rcd_unary.sv
`timescale 1ns/100ps
`include "rcd_params.svh"

module rcd_unary (
  input wire logic [3:0] opcode,
  input wire logic [3:0] sub,
  input wire logic [3:0] imm,
  input wire logic [31:0] src_x,
  input wire logic [31:0] src_hi,
  output logic [31:0] result
);

  // Single-operand datapath for swap, shift, invert and small add
  always_comb begin
    result = src_x;
    case (opcode)
      `RCD_OP_ADD_SMALL: begin
        result = src_hi + {{28{imm[3]}}, imm};
      end
      `RCD_OP_SWAP: begin
        if (sub == `RCD_SUB_SWAP_BYTES) begin
          result = {src_x[31:16], src_x[7:0], src_x[15:8]};
        end else begin
          result = {src_x[15:0], src_x[31:16]};
        end
      end
      `RCD_OP_SHIFT: begin
        if (sub == `RCD_SUB_SHR_LOGIC) begin
          result = {1'b0, src_x[31:1]};
        end else if (sub == `RCD_SUB_SHR_ARITH) begin
          result = {src_x[31], src_x[31:1]};
        end else begin
          result = ~src_x;
        end
      end
      default: begin
        result = src_x;
      end
    endcase
  end

endmodule // rcd_unary
